// ---- ecu_capture.v ----
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ecu_capture_regs.vh"
// Operation
// - Each qualifying event copies the 16-bit wide counter into the capture value.
// - Mode selects falling, rising, every 4th rising, every 16th rising, or both edges.
// - Each capture sets the event flag; only software or a reset clears it.
// - A new capture overwrites the stored value, no older value kept.
// - Capture value readable as separate low and high bytes.
// - Prescaler counter held clear while disabled or not in capture mode.
// - Every reset clears the prescaler counter.
// - Switching between prescale modes keeps the counter; a spurious flag may result.
// - Capture source comes from the input select field.
// - Edge detector sees the actual pin level, even while driven as output.
// - Capture uses the 16-bit wide counter; PWM would use the period timer.
// - Several units may share one timer when in the same mode group.
// - On instruction clock the wide counter stops in sleep and resumes after.
// - Capture keeps working in sleep with an external counter clock.
// - In output modes the pin driver may be configured as open-drain.
module ecu_capture (
  input  wire        sys_clk_i,
  input  wire        rst_n_i,
  input  wire [3:0]  reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [7:0]  reg_rdata_o,
  input  wire        capture_unit_pin_i,
  input  wire        alt_src1_i,
  input  wire        alt_src2_i,
  input  wire        alt_src3_i,
  input  wire        ext_count_clk_i,
  input  wire        sleep_i,
  input  wire        compare_out_i,
  output reg         pin_out_o,
  output reg         pin_oe_n_o,
  output reg         capture_event_flag_o,
  output reg         capture_pulse_o
);
  reg  [7:0]  capture_control_reg;
  reg  [1:0]  capture_input_select_reg;
  reg  [1:0]  counter_ctl_reg;
  reg  [15:0] capture_value_pair_reg;
  reg  [15:0] wide_counter_value_reg;
  reg  [3:0]  prescale_reg;
  reg  [3:0]  prescale_next;
  reg  [1:0]  instr_div_reg;
  reg         src_prev_reg;
  reg         ext_prev_reg;
  reg         capture_now;
  reg         src_sel;
  reg  [7:0]  rdata_next;
  reg         pin_out_next;
  reg         pin_oe_n_next;

  wire        pin_s;
  wire        alt1_s;
  wire        alt2_s;
  wire        alt3_s;
  wire        ext_s;
  wire [3:0]  mode;
  wire        enabled;
  wire        in_capture;
  wire        rise_edge;
  wire        fall_edge;
  wire        instr_tick;
  wire        ext_tick;
  wire        count_tick;
  wire        flag_clear;

  assign mode       = capture_control_reg[`ECU_CTL_MODE_MSB:`ECU_CTL_MODE_LSB];
  assign enabled    = capture_control_reg[`ECU_CTL_EN_BIT];
  assign in_capture = enabled && (mode == `ECU_MODE_BOTH || mode == `ECU_MODE_FALL ||
                      mode == `ECU_MODE_RISE || mode == `ECU_MODE_RISE4 ||
                      mode == `ECU_MODE_RISE16);

  ecu_sync2 u_sync_pin (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   (capture_unit_pin_i),
    .sync_o    (pin_s)
  );
  ecu_sync2 u_sync_a1 (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   (alt_src1_i),
    .sync_o    (alt1_s)
  );
  ecu_sync2 u_sync_a2 (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   (alt_src2_i),
    .sync_o    (alt2_s)
  );
  ecu_sync2 u_sync_a3 (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   (alt_src3_i),
    .sync_o    (alt3_s)
  );
  ecu_sync2 u_sync_ext (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   (ext_count_clk_i),
    .sync_o    (ext_s)
  );

  always @* begin
    case (capture_input_select_reg)
      2'h0:    src_sel = pin_s;
      2'h1:    src_sel = alt1_s;
      2'h2:    src_sel = alt2_s;
      default: src_sel = alt3_s;
    endcase
  end

  // pin level sampled at the pad, whatever drives it
  assign rise_edge = src_sel & ~src_prev_reg;
  assign fall_edge = ~src_sel & src_prev_reg;

  always @* begin
    capture_now   = 1'b0;
    prescale_next = prescale_reg;
    if (!in_capture) begin
      prescale_next = 4'h0;
    end else if (mode == `ECU_MODE_FALL) begin
      capture_now = fall_edge;
    end else if (mode == `ECU_MODE_RISE) begin
      capture_now = rise_edge;
    end else if (mode == `ECU_MODE_BOTH) begin
      capture_now = rise_edge | fall_edge;
    end else if (rise_edge) begin
      if ((mode == `ECU_MODE_RISE4 && prescale_reg[1:0] == `ECU_PS4_LAST) ||
          (mode == `ECU_MODE_RISE16 && prescale_reg == `ECU_PS16_LAST)) begin
        capture_now = 1'b1;
      end
      prescale_next = prescale_reg + 4'h1;
    end
  end

  // Instruction clock enable: system clock divided by four
  assign instr_tick = (instr_div_reg == `ECU_INSTR_DIV_LAST);
  assign ext_tick   = ext_s & ~ext_prev_reg;
  // instruction-clocked count stops in sleep, holds its value
  // external clock keeps counting through sleep
  assign count_tick = counter_ctl_reg[`ECU_CNT_RUN_BIT] &&
                      (counter_ctl_reg[`ECU_CNT_EXT_BIT] ? ext_tick : (instr_tick && !sleep_i));

  assign flag_clear = reg_wr_i && reg_addr_i == `ECU_OFS_FLAG && !reg_wdata_i[0];

  // Software-visible control registers
  // Value bytes live in their own process so that a capture can win
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      capture_control_reg      <= `ECU_CONTROL_RST;
      capture_input_select_reg <= `ECU_INSEL_RST;
      counter_ctl_reg          <= `ECU_CNTCTL_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `ECU_OFS_CONTROL) begin
        capture_control_reg <= reg_wdata_i;
      end else if (reg_addr_i == `ECU_OFS_INPUT_SEL) begin
        capture_input_select_reg <= reg_wdata_i[1:0];
      end else if (reg_addr_i == `ECU_OFS_COUNTER_CTL) begin
        counter_ctl_reg <= reg_wdata_i[1:0];
      end
    end
  end

  // Previous levels for edge detection; free-running divide-by-four phase
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_prev_reg  <= 1'b0;
      ext_prev_reg  <= 1'b0;
      instr_div_reg <= 2'h0;
    end else begin
      src_prev_reg  <= src_sel;
      ext_prev_reg  <= ext_s;
      instr_div_reg <= instr_div_reg + 2'h1;
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prescale_reg <= 4'h0;
    end else begin
      prescale_reg <= prescale_next;
    end
  end

  // one time base shared by every capture or compare user
  // Counts only on enable pulses, never on the raw system clock
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wide_counter_value_reg <= 16'h0000;
    end else if (count_tick) begin
      wide_counter_value_reg <= wide_counter_value_reg + 16'h0001;
    end
  end

  // capture time base is the wide counter
  // latch the count on an event
  // newest value overwrites; a capture beats a software write
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      capture_value_pair_reg <= 16'h0000;
    end else if (capture_now) begin
      capture_value_pair_reg <= wide_counter_value_reg;
    end else if (reg_wr_i && reg_addr_i == `ECU_OFS_VALUE_LOW) begin
      capture_value_pair_reg[7:0] <= reg_wdata_i;
    end else if (reg_wr_i && reg_addr_i == `ECU_OFS_VALUE_HIGH) begin
      capture_value_pair_reg[15:8] <= reg_wdata_i;
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      capture_event_flag_o <= 1'b0;
      capture_pulse_o      <= 1'b0;
    end else begin
      capture_pulse_o <= capture_now;
      if (capture_now) begin
        capture_event_flag_o <= 1'b1;
      end else if (flag_clear) begin
        capture_event_flag_o <= 1'b0;
      end
    end
  end

  // open-drain option only in output modes; capture keeps the pad released
  always @* begin
    pin_out_next  = 1'b0;
    pin_oe_n_next = 1'b1;
    if (enabled && !in_capture) begin
      if (capture_control_reg[`ECU_CTL_OD_BIT]) begin
        // Open drain: pull low, or release and let the external pull-up win
        pin_oe_n_next = compare_out_i;
      end else begin
        pin_out_next  = compare_out_i;
        pin_oe_n_next = 1'b0;
      end
    end
  end

  // Pad drive registered so the pin never sees decode glitches
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_out_o  <= 1'b0;
      pin_oe_n_o <= 1'b1;
    end else begin
      pin_out_o  <= pin_out_next;
      pin_oe_n_o <= pin_oe_n_next;
    end
  end

  // read mux: control, select, flag, counter control, and byte halves of the value and count
  always @* begin
    rdata_next = 8'h00;
    // Unmapped addresses fall through to zero
    if (reg_rd_i) begin
      if (reg_addr_i == `ECU_OFS_CONTROL) begin
        rdata_next = capture_control_reg;
      end else if (reg_addr_i == `ECU_OFS_INPUT_SEL) begin
        rdata_next = {6'h00, capture_input_select_reg};
      end else if (reg_addr_i == `ECU_OFS_VALUE_LOW) begin
        rdata_next = capture_value_pair_reg[7:0];
      end else if (reg_addr_i == `ECU_OFS_VALUE_HIGH) begin
        rdata_next = capture_value_pair_reg[15:8];
      end else if (reg_addr_i == `ECU_OFS_FLAG) begin
        rdata_next = {7'h00, capture_event_flag_o};
      end else if (reg_addr_i == `ECU_OFS_COUNTER_CTL) begin
        rdata_next = {6'h00, counter_ctl_reg};
      end else if (reg_addr_i == `ECU_OFS_COUNT_LOW) begin
        rdata_next = wide_counter_value_reg[7:0];
      end else if (reg_addr_i == `ECU_OFS_COUNT_HIGH) begin
        rdata_next = wide_counter_value_reg[15:8];
      end
    end
  end

  // Read data stand one cycle after the strobe, zero otherwise
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= rdata_next;
    end
  end
endmodule // ecu_capture
`default_nettype wire

// ---- ecu_capture_regs.vh ----
`ifndef ECU_CAPTURE_REGS_VH
`define ECU_CAPTURE_REGS_VH
// Register offsets (byte addresses on the plain register port)
`define ECU_OFS_CONTROL      4'h0
`define ECU_OFS_INPUT_SEL    4'h1
`define ECU_OFS_VALUE_LOW    4'h2
`define ECU_OFS_VALUE_HIGH   4'h3
`define ECU_OFS_FLAG         4'h4
`define ECU_OFS_COUNTER_CTL  4'h5
`define ECU_OFS_COUNT_LOW    4'h6
`define ECU_OFS_COUNT_HIGH   4'h7
// capture_control fields
`define ECU_CTL_EN_BIT       7
`define ECU_CTL_OD_BIT       6
`define ECU_CTL_MODE_MSB     3
`define ECU_CTL_MODE_LSB     0
// Mode encodings
`define ECU_MODE_OFF         4'h0
`define ECU_MODE_BOTH        4'h3
`define ECU_MODE_FALL        4'h4
`define ECU_MODE_RISE        4'h5
`define ECU_MODE_RISE4       4'h6
`define ECU_MODE_RISE16      4'h7
`define ECU_MODE_PWM         4'hF
// Counter control fields
`define ECU_CNT_RUN_BIT      0
`define ECU_CNT_EXT_BIT      1
// Reset values
`define ECU_CONTROL_RST      8'h00
`define ECU_INSEL_RST        2'h0
`define ECU_CNTCTL_RST       2'h0
// Prescaler terminal counts
`define ECU_PS4_LAST         2'h3
`define ECU_PS16_LAST        4'hF
// Instruction clock divide (system clock / 4)
`define ECU_INSTR_DIV_LAST   2'h3
`endif

// ---- ecu_sync2.v ----
`timescale 1ns/100ps
`default_nettype none
module ecu_sync2 (
  input  wire sys_clk_i,
  input  wire rst_n_i,
  input  wire async_i,
  output reg  sync_o
);
  reg meta_reg;

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= 1'b0;
      sync_o   <= 1'b0;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end
endmodule // ecu_sync2
`default_nettype wire

// ---- ecu_capture_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module ecu_capture_chk (
  input wire logic       sys_clk_i,
  input wire logic       rst_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       pin_oe_n_o,
  input wire logic       capture_event_flag_o,
  input wire logic       capture_pulse_o
);
  logic [7:0] ctl_reg;
  logic [1:0] off_cnt_reg;
  // Off count saturates; three quiet cycles outlast any capture still in flight
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl_reg <= 8'h00;
      off_cnt_reg <= 2'h0;
    end else begin
      if (reg_wr_i && reg_addr_i == 4'h0) ctl_reg <= reg_wdata_i;
      if (ctl_reg[7]) off_cnt_reg <= 2'h0;
      else if (off_cnt_reg != 2'h3) off_cnt_reg <= off_cnt_reg + 2'h1;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_ctl_wr; reg_wr_i && reg_addr_i == 4'h0; endsequence
  sequence s_ctl_rd; reg_rd_i && reg_addr_i == 4'h0; endsequence
  a_ctl_readback: assert property (s_ctl_wr ##2 s_ctl_rd |=>
    (reg_rdata_o & 8'hCF) == ($past(reg_wdata_i, 3) & 8'hCF)) else $error("control readback");
  a_rd_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00) else $error("rdata not idle");
  a_unmapped_zero: assert property (reg_rd_i && reg_addr_i[3] |=> reg_rdata_o == 8'h00)
    else $error("unmapped read");
  a_pulse_single: assert property (capture_pulse_o |=> !capture_pulse_o) else $error("long pulse");
  a_pulse_flag: assert property (capture_pulse_o |-> capture_event_flag_o) else $error("no flag");
  a_flag_cause: assert property ($rose(capture_event_flag_o) |-> capture_pulse_o)
    else $error("flag without capture");
  a_flag_sticky: assert property (capture_event_flag_o && !(reg_wr_i && reg_addr_i == 4'h4)
    |=> capture_event_flag_o) else $error("flag dropped");
  a_flag_clear: assert property (capture_event_flag_o && reg_wr_i && reg_addr_i == 4'h4
    && !reg_wdata_i[0] ##1 !capture_pulse_o |-> !capture_event_flag_o) else $error("flag kept");
  a_off_quiet: assert property (off_cnt_reg == 2'h3 |-> !capture_pulse_o)
    else $error("capture while off");
  a_oe_released: assert property (off_cnt_reg == 2'h3 |-> pin_oe_n_o) else $error("pin driven");
endmodule // ecu_capture_chk
bind ecu_capture ecu_capture_chk ecu_capture_chk_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .pin_oe_n_o(pin_oe_n_o),
  .capture_event_flag_o(capture_event_flag_o), .capture_pulse_o(capture_pulse_o));
`default_nettype wire

// ---- ecu_src_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module ecu_src_model (
  input  wire logic       sys_clk_i,
  output var  logic [3:0] src_o,
  output var  logic       ext_clk_o
);
  int idx_v;
  initial begin
    src_o = 4'h0;
    ext_clk_o = 1'b0;
  end
  // pin stays an input, level set here
  task pulse(input int idx);
    idx_v = idx;
    @(posedge sys_clk_i);
    src_o[idx_v] <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    src_o[idx_v] <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
  endtask
  // external count clock, still between bursts
  task ext_edges(input int n);
    repeat (n) begin
      @(posedge sys_clk_i);
      ext_clk_o <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      ext_clk_o <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
    end
  endtask
endmodule // ecu_src_model
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "ecu_capture_regs.vh"
module tb;
  typedef struct {logic [3:0] m1; int n1; bit zero; logic [3:0] m2; int n2; int exp;} ecu_row_t;
  logic       sys_clk_i, rst_n_i, reg_wr_i, reg_rd_i, ext_clk, pin_out, pin_oe_n, flag, pulse;
  logic       sleep, cmp_out;
  logic [3:0] reg_addr_i, src;
  logic [7:0] reg_wdata_i, reg_rdata_o, d, d0;
  int         mismatches, n_compared, captures, cycles;
  ecu_row_t   rows [8];
  ecu_src_model src_model_inst (.sys_clk_i(sys_clk_i), .src_o(src), .ext_clk_o(ext_clk));
  ecu_capture ecu_capture_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .capture_unit_pin_i(src[0]), .alt_src1_i(src[1]), .alt_src2_i(src[2]), .alt_src3_i(src[3]),
    .ext_count_clk_i(ext_clk), .sleep_i(sleep), .compare_out_i(cmp_out), .pin_out_o(pin_out),
    .pin_oe_n_o(pin_oe_n), .capture_event_flag_o(flag), .capture_pulse_o(pulse));
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  // Counting only on a pulse avoids racing the bench's own clearing
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (pulse === 1'b1) captures <= captures + 1;
    if (cycles == 6000) begin
      mismatches++;
      wrap_up;
    end
  end
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task cmp_n(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      mismatches++;
      $display("[ERR] %0t captures %0d expected %0d", $time, got, exp);
    end
  endtask
  task drive_pad(input logic c);
    @(posedge sys_clk_i);
    cmp_out <= c;
    repeat (2) @(posedge sys_clk_i);
    #1 d = {6'h00, pin_out, pin_oe_n};
  endtask
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    rows = '{'{`ECU_MODE_OFF, 0, 0, `ECU_MODE_FALL, 3, 3}, '{`ECU_MODE_OFF, 0, 0, `ECU_MODE_RISE, 3, 3},
      '{`ECU_MODE_OFF, 0, 0, `ECU_MODE_BOTH, 3, 6}, '{`ECU_MODE_OFF, 0, 0, `ECU_MODE_RISE4, 8, 2},
      '{`ECU_MODE_OFF, 0, 0, `ECU_MODE_RISE16, 16, 1}, '{`ECU_MODE_OFF, 0, 0, `ECU_MODE_OFF, 4, 0},
      '{`ECU_MODE_RISE4, 2, 1, `ECU_MODE_RISE4, 3, 0}, '{`ECU_MODE_RISE4, 2, 0, `ECU_MODE_RISE16, 14, 1}};
    {rst_n_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, sleep, cmp_out} = '0;
    {mismatches, n_compared, captures, cycles} = '0;
    repeat (12) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd(`ECU_OFS_CONTROL); cmp8(d, `ECU_CONTROL_RST);
    rd(4'h9); cmp8(d, 8'h00);
    cmp8({7'h0, pin_oe_n}, 8'h01);
    $display("test reset done");
    wr(`ECU_OFS_COUNTER_CTL, 8'h03);
    src_model_inst.ext_edges(5);
    wr(`ECU_OFS_CONTROL, 8'h85);
    rd(`ECU_OFS_CONTROL); cmp8(d & 8'hCF, 8'h85);
    src_model_inst.pulse(0);
    src_model_inst.ext_edges(3);
    src_model_inst.pulse(0);
    // Unit off first, so both bytes come from one event
    wr(`ECU_OFS_CONTROL, 8'h00);
    rd(`ECU_OFS_VALUE_LOW); cmp8(d, 8'h08);
    rd(`ECU_OFS_VALUE_HIGH); cmp8(d, 8'h00);
    rd(`ECU_OFS_COUNT_LOW); cmp8(d, 8'h08);
    rd(`ECU_OFS_FLAG); cmp8(d, 8'h01);
    wr(`ECU_OFS_FLAG, 8'h01);
    rd(`ECU_OFS_FLAG); cmp8(d, 8'h01);
    wr(`ECU_OFS_FLAG, 8'h00);
    rd(`ECU_OFS_FLAG); cmp8(d, 8'h00);
    $display("test value done");
    wr(`ECU_OFS_INPUT_SEL, 8'h02);
    wr(`ECU_OFS_CONTROL, 8'h85);
    captures = 0;
    src_model_inst.pulse(0); cmp_n(captures, 0);
    src_model_inst.pulse(2); cmp_n(captures, 1);
    wr(`ECU_OFS_INPUT_SEL, 8'h00);
    wr(`ECU_OFS_CONTROL, 8'h86);
    repeat (2) src_model_inst.pulse(0);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    wr(`ECU_OFS_CONTROL, 8'h86);
    captures = 0;
    repeat (3) src_model_inst.pulse(0);
    cmp_n(captures, 0);
    $display("test select and reset done");
    wr(`ECU_OFS_COUNTER_CTL, 8'h01);
    for (int k = 0; k < 3; k++) begin
      rd(`ECU_OFS_COUNT_LOW); d0 = d;
      repeat (38) @(posedge sys_clk_i);
      rd(`ECU_OFS_COUNT_LOW); cmp8(d - d0, (k == 1) ? 8'h00 : 8'h0A);
      @(posedge sys_clk_i) sleep <= (k == 0);
    end
    @(posedge sys_clk_i) sleep <= 1'b1;
    wr(`ECU_OFS_COUNTER_CTL, 8'h03);
    wr(`ECU_OFS_CONTROL, 8'h85);
    rd(`ECU_OFS_COUNT_LOW); d0 = d;
    src_model_inst.ext_edges(4);
    src_model_inst.pulse(0);
    rd(`ECU_OFS_COUNT_LOW); cmp8(d - d0, 8'h04);
    rd(`ECU_OFS_VALUE_LOW); cmp8(d - d0, 8'h04);
    @(posedge sys_clk_i) sleep <= 1'b0;
    wr(`ECU_OFS_CONTROL, 8'hC1);
    drive_pad(1'b0); cmp8(d, 8'h00);
    drive_pad(1'b1); cmp8(d, 8'h01);
    wr(`ECU_OFS_CONTROL, 8'h8F);
    drive_pad(1'b1); cmp8(d, 8'h02);
    drive_pad(1'b0); cmp8(d, 8'h00);
    wr(`ECU_OFS_CONTROL, 8'h00);
    drive_pad(1'b1); cmp8(d, 8'h01);
    $display("test counter and pad done");
    foreach (rows[i]) begin
      wr(`ECU_OFS_CONTROL, 8'h00);
      wr(`ECU_OFS_CONTROL, 8'h80 | rows[i].m1);
      repeat (rows[i].n1) src_model_inst.pulse(0);
      // control zeroed before a new prescale
      if (rows[i].zero) wr(`ECU_OFS_CONTROL, 8'h00);
      wr(`ECU_OFS_CONTROL, 8'h80 | rows[i].m2);
      // flag cleared after the mode change
      wr(`ECU_OFS_FLAG, 8'h00);
      captures = 0;
      repeat (rows[i].n2) src_model_inst.pulse(0);
      cmp_n(captures, rows[i].exp);
      $display("test row %0d done", i);
    end
    wrap_up;
  end
endmodule // tb
`default_nettype wire
